// ---- design/lfo_pkg.sv ----
// Package for the low-frequency oscillator and external oscillator pin control.
// Assumes an 8-bit special-function register bus, one 100 MHz clock, synchronous reset.
package lfo_pkg;
    localparam logic [7:0] LFO_CTRL_ADDR = 8'h86;
    localparam logic [7:0] LFO_EXT_CTRL_ADDR = 8'hb1;
    localparam int LFO_EN_BIT = 7;
    localparam int LFO_RDY_BIT = 6;
    localparam int LFO_TRIM_LSB = 2;
    localparam int LFO_DIV_LSB = 0;
    localparam logic [3:0] LFO_TRIM_RESET = 4'h8;
    localparam logic [1:0] LFO_DIV_RESET = 2'h0;
    // Nominal undivided frequency in kHz and the clock rate in kHz
    localparam int LFO_NOMINAL_KHZ = 80;
    localparam int LFO_CLK_KHZ = 100000;
    localparam int LFO_BASE_HALF = LFO_CLK_KHZ / LFO_NOMINAL_KHZ / 2;
    // Extra half-period cycles added per trim step
    localparam int LFO_TRIM_STEP = 16;
    localparam int LFO_CNT_W = 12;
    localparam logic [7:0] LFO_SETTLE_CYCLES = 8'h10;
    // External oscillator mode field
    localparam int LFO_XMODE_LSB = 4;
    localparam logic [2:0] LFO_XMODE_CMOS = 3'h2;
    localparam logic [2:0] LFO_XMODE_CMOS_DIV2 = 3'h3;
    localparam logic [2:0] LFO_XMODE_RC = 3'h4;
    localparam logic [2:0] LFO_XMODE_CAP = 3'h5;
    localparam logic [2:0] LFO_XMODE_XTAL = 3'h6;
    localparam logic [2:0] LFO_XMODE_XTAL_DIV2 = 3'h7;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } lfo_sfr_req_t;

    typedef struct packed {
        logic crystal_in_owned;
        logic crystal_out_owned;
        logic crystal_mode;
    } lfo_pin_t;
endpackage

// ---- design/lfo_div.sv ----
// Power-of-two output divider of the low-frequency oscillator tick stream.
// Assumes tick_i is a one-cycle pulse per undivided oscillator rising edge.
`timescale 1ns/100ps
module lfo_div (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic clear_i,
    input wire logic tick_i,
    input wire logic [1:0] sel_i,
    output logic tick_o
);
    import lfo_pkg::*;

    typedef struct packed {
        logic [2:0] cnt;
        logic out;
    } lfo_div_state_t;

    lfo_div_state_t s_q, s_d;
    logic [2:0] limit;

    always_comb begin
        s_d = s_q;
        // 00 divides by 8, 01 by 4, 10 by 2, 11 by 1
        case (sel_i)
            2'h0: limit = 3'h7;
            2'h1: limit = 3'h3;
            2'h2: limit = 3'h1;
            default: limit = 3'h0;
        endcase
        s_d.out = 1'b0;
        if (clear_i) begin
            s_d.cnt = 3'h0;
        end else if (tick_i) begin
            if (s_q.cnt >= limit) begin
                s_d.cnt = 3'h0;
                s_d.out = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt + 3'h1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick_o = s_q.out;
endmodule

// ---- design/lfo_ctrl.sv ----
// Low-frequency oscillator control register, behavioural oscillator, output divider
// and external oscillator pin allocation.
// Assumes a synchronous single-cycle register port at 100 MHz; ext clock pin is asynchronous.
//
// Summary of operation
// [RULE1] The oscillator runs only while the enable bit (bit 7) is one and is stopped when it is zero.
// [RULE2] Bit 6 is a read-only ready flag that reads one once the frequency has stabilised.
// [RULE3] Once set, the ready flag clears only on reset or on a write that changes the divider field.
// [RULE4] Bits 5 to 2 are a trim where zero is fastest and all ones is slowest, monotonic between.
// [RULE5] Software should change the trim only while the oscillator is disabled.
// [RULE6] Bits 1 to 0 select divide by 8, 4, 2 or 1 for codes 00, 01, 10 and 11.
// [RULE7] Enable, ready and divider reset to zero, the trim to a calibrated value.
// [RULE8] In crystal or resonator mode the external circuit takes P0.2 as crystal input and P0.3 as output.
// [RULE9] In capacitor, RC or CMOS mode only P0.3 is used and P0.2 stays general purpose.
// [RULE10] Software should make the crossbar skip the pins the oscillator occupies.
// [RULE11] In crystal, resonator, capacitor or RC mode software should set the pins to analog input.
// [RULE12] In CMOS clock mode software should set the oscillator input pin to digital input.
// [RULE13] The external drive supports crystal, resonator, capacitor, RC or CMOS input, set by its own register.
// [RULE14] The external oscillator output may be the system clock or clock selected peripherals.
// [RULE15] The oscillator is calibrated to a nominal 80 kHz before the divider; the code gives 80 kHz only at trim 0, about 66 kHz at the reset trim of 8.
// [RULE16] Ready asserts after a fixed count of oscillator cycles after enable or divider change.
`timescale 1ns/100ps
module lfo_ctrl #(
    parameter logic [3:0] TRIM_CAL = lfo_pkg::LFO_TRIM_RESET,
    parameter logic [7:0] SETTLE_CYCLES = lfo_pkg::LFO_SETTLE_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire lfo_pkg::lfo_sfr_req_t sfr_req_i,
    input wire logic ext_clk_pin_i,
    input wire logic sysclk_sel_ext_i,
    output logic [7:0] sfr_rdata_o,
    output logic lf_osc_running_o,
    output logic lf_osc_tick_o,
    output logic ext_clk_tick_o,
    output logic sysclk_from_ext_o,
    output lfo_pkg::lfo_pin_t pins_o
);
    import lfo_pkg::*;

    localparam logic [LFO_CNT_W-1:0] BASE_HALF = LFO_CNT_W'(LFO_BASE_HALF);
    localparam logic [LFO_CNT_W-1:0] TRIM_STEP = LFO_CNT_W'(LFO_TRIM_STEP);

    typedef enum logic [2:0] {
        ST_OFF = 3'b001,
        ST_SETTLE = 3'b010,
        ST_READY = 3'b100
    } lfo_state_t;

    typedef struct packed {
        lfo_state_t st;
        logic lf_osc_enable;
        logic lf_osc_ready;
        logic [3:0] lf_freq_trim;
        logic [1:0] lf_divider_select;
        logic [7:0] ext_osc_control;
        logic [LFO_CNT_W-1:0] half_cnt;
        logic osc_level;
        logic [7:0] settle_cnt;
        logic [7:0] rdata;
        logic running;
        logic ext_s1;
        logic ext_s2;
        logic ext_s3;
        logic ext_tick;
        logic tick;
        logic sys_ext;
        lfo_pin_t pins;
    } lfo_ctrl_state_t;

    lfo_ctrl_state_t s_q, s_d;
    logic osc_edge;
    logic div_clear;
    logic div_tick;
    logic wr_ctrl;
    logic wr_ext;
    logic div_changed;
    logic [2:0] xmode;
    logic [LFO_CNT_W-1:0] half_period;

    assign wr_ctrl = sfr_req_i.wr && (sfr_req_i.addr == LFO_CTRL_ADDR);
    assign wr_ext = sfr_req_i.wr && (sfr_req_i.addr == LFO_EXT_CTRL_ADDR);
    assign div_changed = wr_ctrl && (sfr_req_i.wdata[LFO_DIV_LSB +: 2] != s_q.lf_divider_select);
    assign xmode = s_q.ext_osc_control[LFO_XMODE_LSB +: 3];
    // Slower setting means a longer half period
    assign half_period = BASE_HALF + TRIM_STEP * LFO_CNT_W'(s_q.lf_freq_trim); // see [RULE4] see [RULE15]
    assign osc_edge = s_q.lf_osc_enable && (s_q.half_cnt >= half_period - LFO_CNT_W'(1));
    assign div_clear = !s_q.lf_osc_enable || div_changed;

    lfo_div u_div (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .clear_i(div_clear),
        .tick_i(osc_edge && !s_q.osc_level),
        .sel_i(s_q.lf_divider_select),
        .tick_o(div_tick)
    ); // see [RULE6]

    always_comb begin
        s_d = s_q;
        if (wr_ctrl) begin
            s_d.lf_osc_enable = sfr_req_i.wdata[LFO_EN_BIT];
            s_d.lf_freq_trim = sfr_req_i.wdata[LFO_TRIM_LSB +: 4];
            s_d.lf_divider_select = sfr_req_i.wdata[LFO_DIV_LSB +: 2];
        end
        if (wr_ext) begin
            s_d.ext_osc_control = sfr_req_i.wdata;
        end
        // Behavioural oscillator: toggles only while enabled
        if (!s_q.lf_osc_enable) begin // see [RULE1]
            s_d.half_cnt = '0;
            s_d.osc_level = 1'b0;
        end else if (osc_edge) begin
            s_d.half_cnt = '0;
            s_d.osc_level = !s_q.osc_level;
        end else begin
            s_d.half_cnt = s_q.half_cnt + LFO_CNT_W'(1);
        end
        s_d.running = s_q.lf_osc_enable;
        s_d.tick = div_tick; // see [RULE6]
        // Ready sequencing
        case (s_q.st)
            ST_OFF: begin
                s_d.settle_cnt = '0;
                if (s_q.lf_osc_enable) begin
                    s_d.st = ST_SETTLE;
                end
            end
            ST_SETTLE: begin
                if (osc_edge && !s_q.osc_level) begin
                    s_d.settle_cnt = s_q.settle_cnt + 8'h1;
                end
                if (s_q.settle_cnt >= SETTLE_CYCLES) begin // see [RULE16]
                    s_d.st = ST_READY;
                    s_d.lf_osc_ready = 1'b1; // see [RULE2]
                end
            end
            ST_READY: begin
                s_d.settle_cnt = '0;
            end
            default: begin
                s_d.st = ST_OFF;
            end
        endcase
        // Only a divider change clears ready; disabling does not
        if (div_changed) begin // see [RULE3]
            s_d.lf_osc_ready = 1'b0;
            s_d.settle_cnt = '0;
            s_d.st = ST_OFF;
        end else if (s_q.st == ST_READY) begin
            s_d.lf_osc_ready = 1'b1;
        end
        if (s_q.st != ST_READY && !s_q.lf_osc_enable && s_q.st != ST_OFF) begin
            s_d.st = ST_OFF;
        end
        // External oscillator pin ownership
        s_d.pins.crystal_mode = (xmode == LFO_XMODE_XTAL) || (xmode == LFO_XMODE_XTAL_DIV2);
        s_d.pins.crystal_in_owned = s_d.pins.crystal_mode; // see [RULE8]
        s_d.pins.crystal_out_owned = (xmode >= LFO_XMODE_CMOS); // see [RULE9] see [RULE13]
        // External clock synchroniser and edge tick
        s_d.ext_s1 = ext_clk_pin_i;
        s_d.ext_s2 = s_q.ext_s1;
        s_d.ext_s3 = s_q.ext_s2;
        s_d.ext_tick = s_q.pins.crystal_out_owned && s_q.ext_s2 && !s_q.ext_s3; // see [RULE14]
        s_d.sys_ext = sysclk_sel_ext_i && s_q.pins.crystal_out_owned;
        // Read data
        if (sfr_req_i.rd && sfr_req_i.addr == LFO_CTRL_ADDR) begin
            s_d.rdata = {s_q.lf_osc_enable, s_q.lf_osc_ready, s_q.lf_freq_trim, s_q.lf_divider_select};
        end else if (sfr_req_i.rd && sfr_req_i.addr == LFO_EXT_CTRL_ADDR) begin
            s_d.rdata = {1'b0, s_q.ext_osc_control[6:0]};
        end else if (sfr_req_i.rd) begin
            s_d.rdata = 8'h00;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s_q <= '0; // see [RULE7]
            s_q.st <= ST_OFF;
            s_q.lf_freq_trim <= TRIM_CAL;
            s_q.lf_divider_select <= LFO_DIV_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign sfr_rdata_o = s_q.rdata;
    assign lf_osc_tick_o = s_q.tick;
    assign lf_osc_running_o = s_q.running;
    assign ext_clk_tick_o = s_q.ext_tick;
    assign sysclk_from_ext_o = s_q.sys_ext;
    assign pins_o = s_q.pins;
endmodule

// ---- bench/lfo_ctrl_sva.sv ----
// Concurrent checks on the oscillator control block's ports.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/100ps
module lfo_ctrl_sva import lfo_pkg::*; #(
    parameter logic [3:0] TRIM_CAL = LFO_TRIM_RESET,
    parameter logic [7:0] SETTLE_CYCLES = LFO_SETTLE_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire lfo_pkg::lfo_sfr_req_t sfr_req_i,
    input wire logic ext_clk_pin_i,
    input wire logic sysclk_sel_ext_i,
    input wire logic [7:0] sfr_rdata_o,
    input wire logic lf_osc_running_o,
    input wire logic lf_osc_tick_o,
    input wire logic ext_clk_tick_o,
    input wire logic sysclk_from_ext_o,
    input wire lfo_pkg::lfo_pin_t pins_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    logic [1:0] div_q;
    logic [3:0] since_q;
    wire w86 = sfr_req_i.wr && sfr_req_i.addr == LFO_CTRL_ADDR;
    wire wb1 = sfr_req_i.wr && sfr_req_i.addr == LFO_EXT_CTRL_ADDR;
    wire r86 = sfr_req_i.rd && sfr_req_i.addr == LFO_CTRL_ADDR;
    // Cycles since the last write that changed the divider field
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            div_q <= LFO_DIV_RESET;
            since_q <= 4'hf;
        end else if (w86) begin
            div_q <= sfr_req_i.wdata[1:0];
            since_q <= (sfr_req_i.wdata[1:0] != div_q) ? 4'h0 : since_q + {3'h0, since_q != 4'hf};
        end else if (since_q != 4'hf) begin
            since_q <= since_q + 4'h1;
        end
    end
    AST_EN_RUN: assert property (w86 |-> ##2 lf_osc_running_o == $past(sfr_req_i.wdata[LFO_EN_BIT], 2))
        else $error("running level does not follow enable bit");
    AST_STOP_NO_TICK: assert property (!lf_osc_running_o [*3] |-> !lf_osc_tick_o)
        else $error("tick while oscillator stopped");
    AST_RD_HOLD: assert property (!sfr_req_i.rd |=> $stable(sfr_rdata_o))
        else $error("read data changed without a read");
    AST_RDY_CLR: assert property (r86 && since_q < 4'h8 |=> !sfr_rdata_o[LFO_RDY_BIT])
        else $error("ready still set after divider change");
    AST_TICK_ONE: assert property (lf_osc_tick_o |=> !lf_osc_tick_o)
        else $error("divided tick longer than one cycle");
    AST_XIN: assert property (wb1 |-> ##2 pins_o.crystal_in_owned == &$past(sfr_req_i.wdata[6:5], 2))
        else $error("crystal input pin ownership wrong");
    AST_XOUT: assert property (wb1 |-> ##2 pins_o.crystal_out_owned == |$past(sfr_req_i.wdata[6:5], 2))
        else $error("oscillator output pin ownership wrong");
    AST_SYSCLK: assert property ($stable(sysclk_sel_ext_i) && $stable(pins_o.crystal_out_owned) |->
        sysclk_from_ext_o == (sysclk_sel_ext_i && pins_o.crystal_out_owned))
        else $error("system clock source select wrong");
    AST_EXT_IDLE: assert property (!pins_o.crystal_out_owned [*4] |-> !ext_clk_tick_o)
        else $error("external tick while pin not owned");
endmodule

bind lfo_ctrl lfo_ctrl_sva #(.TRIM_CAL(TRIM_CAL), .SETTLE_CYCLES(SETTLE_CYCLES)) u_sva (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .sfr_req_i(sfr_req_i), .ext_clk_pin_i(ext_clk_pin_i), .sysclk_sel_ext_i(sysclk_sel_ext_i),
    .sfr_rdata_o(sfr_rdata_o), .lf_osc_running_o(lf_osc_running_o), .lf_osc_tick_o(lf_osc_tick_o),
    .ext_clk_tick_o(ext_clk_tick_o), .sysclk_from_ext_o(sysclk_from_ext_o), .pins_o(pins_o));

// ---- bench/lfo_ext_src.sv ----
// Free-running external CMOS clock source model.
// Assumes nothing of the block; the pin is asynchronous to the system clock.
`timescale 1ns/100ps
module lfo_ext_src #(
    parameter int HALF_NS = 37
) (
    output logic clk_o
);
    initial begin
        clk_o = 1'b0;
        // A digital CMOS level on the oscillator input pin
        forever #(HALF_NS) clk_o = ~clk_o;
    end
endmodule

// ---- bench/lfo_ctrl_tb.sv ----
// Self-checking bench for the low-frequency oscillator control block.
// Assumes the bound checker and the external source model are compiled alongside.
`timescale 1ns/100ps
module lfo_ctrl_tb;
    import lfo_pkg::*;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    lfo_sfr_req_t req = '0;
    logic sel_ext = 1'b0;
    logic ext_pin, running, tick, ext_tick, sys_ext;
    logic [7:0] rdata, v;
    lfo_pin_t pins;
    logic [3:0] t;
    logic [31:0] rnd = 32'h702e;
    int mismatches = 0;
    int checks_done = 0;
    int n;
    always #5 clk_i = ~clk_i;
    lfo_ext_src #(.HALF_NS(37)) u_src (.clk_o(ext_pin));
    lfo_ctrl #(.SETTLE_CYCLES(8'h02)) uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .sfr_req_i(req),
        .ext_clk_pin_i(ext_pin), .sysclk_sel_ext_i(sel_ext), .sfr_rdata_o(rdata), .lf_osc_running_o(running),
        .lf_osc_tick_o(tick), .ext_clk_tick_o(ext_tick), .sysclk_from_ext_o(sys_ext), .pins_o(pins));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Clock cycles between divided ticks
    function automatic int period(input logic [3:0] tr, input logic [1:0] sel);
        return 2 * (LFO_BASE_HALF + LFO_TRIM_STEP * tr) << (2'h3 - sel);
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One register write or read, then an idle cycle; v holds the read data
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        req = '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge clk_i);
        #1 req = '0;
        @(posedge clk_i);
        #1 v = rdata;
    endtask
    task automatic tick_gap(output int c);
        c = 0;
        do begin
            @(posedge clk_i);
            #1 c++;
        end while (tick !== 1'b1 && c < 20000);
    endtask
    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        // About 61,000 cycles are expected; stop well short of 100,000
        #850_000;
        mismatches++;
        stop_test();
    end
    initial begin
        repeat (12) @(posedge clk_i);
        #1 rst_n_i = 1'b1;
        acc(0, LFO_CTRL_ADDR, 8'h00);
        check(v, {2'b00, LFO_TRIM_RESET, LFO_DIV_RESET});
        acc(0, LFO_EXT_CTRL_ADDR, 8'h00);
        check(v, 8'h00);
        acc(0, 8'h55, 8'h00);
        check(v, 8'h00);
        rnd = lfsr(rnd);
        t = rnd[3:0];
        acc(1, LFO_CTRL_ADDR, {2'b01, t, 2'h3});
        acc(0, LFO_CTRL_ADDR, 8'h00);
        check(v, {2'b00, t, 2'h3});
        acc(1, LFO_CTRL_ADDR, {2'b10, t, 2'h3});
        n = 0;
        do begin
            acc(0, LFO_CTRL_ADDR, 8'h00);
            n++;
        end while (v[6] !== 1'b1 && n < 4000);
        check(v, {2'b11, t, 2'h3});
        for (int s = 3; s >= 0; s--) begin
            acc(1, LFO_CTRL_ADDR, {2'b10, t, s[1:0]});
            tick_gap(n);
            tick_gap(n);
            check(n, period(t, s[1:0]));
        end
        acc(1, LFO_CTRL_ADDR, {2'b00, t, 2'h0});
        acc(0, LFO_CTRL_ADDR, 8'h00);
        check({running, v}, {1'b0, 2'b01, t, 2'h0});
        n = 0;
        repeat (4000) begin
            @(posedge clk_i);
            #1 n += int'(tick);
        end
        check(n, 0);
        acc(1, LFO_CTRL_ADDR, {2'b00, t, 2'h1});
        acc(0, LFO_CTRL_ADDR, 8'h00);
        check(v, {2'b00, t, 2'h1});
        for (int m = 0; m < 8; m++) begin
            rnd = lfsr(rnd);
            sel_ext = rnd[0];
            acc(1, LFO_EXT_CTRL_ADDR, {1'b1, m[2:0], 1'b0, rnd[3:1]});
            n = 0;
            repeat (40) begin
                @(posedge clk_i);
                #1 n += int'(ext_tick);
            end
            acc(0, LFO_EXT_CTRL_ADDR, 8'h00);
            check(v[7:4], {1'b0, m[2:0]});
            check(pins, {m[2] & m[1], m[2] | m[1], m[2] & m[1]});
            check(sys_ext, sel_ext & (m[2] | m[1]));
            check(n != 0, m[2] | m[1]);
        end
        // Trim end points, each changed only while the oscillator is stopped
        for (int k = 0; k < 2; k++) begin
            acc(1, LFO_CTRL_ADDR, {2'b00, t, 2'h3});
            t = k[0] ? 4'hf : 4'h0;
            acc(1, LFO_CTRL_ADDR, {2'b00, t, 2'h3});
            acc(1, LFO_CTRL_ADDR, {2'b10, t, 2'h3});
            tick_gap(n);
            tick_gap(n);
            check(n, period(t, 2'h3));
        end
        n = 0;
        do begin
            acc(0, LFO_CTRL_ADDR, 8'h00);
            n++;
        end while (v[6] !== 1'b1 && n < 4000);
        check(v, {2'b11, 4'hf, 2'h3});
        // Reset in mid-run clears ready and restores the calibrated trim
        rst_n_i = 1'b0;
        repeat (3) @(posedge clk_i);
        #1 rst_n_i = 1'b1;
        acc(0, LFO_CTRL_ADDR, 8'h00);
        check(v, {2'b00, LFO_TRIM_RESET, LFO_DIV_RESET});
        check({pins, sys_ext, running}, 5'h00);
        stop_test();
    end
endmodule
